/* include/tone_decoder_defs.svh */
// Purpose: Shared offsets, field positions and timing figures of the tone call decoder.
// Assumes: 250 MHz system clock; all pulse timing is counted in 1 ms ticks.
// Notes:   Times are in milliseconds unless the name says otherwise.
`ifndef TONE_DECODER_DEFS_SVH
`define TONE_DECODER_DEFS_SVH

// ----------------------------------------
// Clock and tick
// ----------------------------------------
`define CLK_MHZ          250
`define TICK_US          1000
`define TICK_CYCLES      (`TICK_US * `CLK_MHZ)

// ----------------------------------------
// Tone detector positions
// ----------------------------------------
`define TONE_1A          0
`define TONE_1B          1
`define TONE_2A          2
`define TONE_2B          3
`define TONE_N           4

// ----------------------------------------
// Timing in milliseconds
// ----------------------------------------
`define MS_W             16
`define FIRST_NOM_MS     1250
`define FIRST_TOL_MS     250
`define GAP_NOM_MS       200
`define GAP_MAX_MS       400
`define SECOND_NOM_MS    1000
`define SECOND_TOL_MS    200
`define GROUP_HOLD_MS    3000
`define ALERT_MS         2000
`define MONITOR_MS       5000
`define DEBOUNCE_MS      20
`define DB_W             8

// ----------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------
`define ADDR_W           12
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_MASK         12'h008
`define REG_STATE        12'h00C
`define CTRL_TONE_ONLY   0
`define CTRL_SOFT_RESET  1
`define EVT_INDIV        0
`define EVT_GROUP        1
`define EVT_ABORT        2
`define EVT_N            3
`define ST_LAMP          0
`define ST_ALERT         1
`define ST_UNMUTE        2
`define ST_HORN          3
`define ST_LIGHTS        4
`define ST_MUTE          5
`define ST_TONES_LSB     8

`endif

/* include/tone_decoder_pkg.sv */
// Purpose: Types shared by the tone call decoder modules.
// Assumes: Nothing beyond the defs header.
// Notes:   State encodings are left to the tools.
package tone_decoder_pkg;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_GAP, SEQ_SECOND} seq_state_t;

	typedef enum logic [2:0] {CALL_IDLE, CALL_ALERT, CALL_MONITOR, CALL_HELD, CALL_DONE} call_state_t;

endpackage : tone_decoder_pkg

/* include/tone_if.sv */
// Purpose: Carries the cleaned tone detector levels from the debouncer to the decoder.
// Assumes: Single clock domain.
// Notes:   One bit per detector position.
`timescale 1ns/1ps
`include "tone_decoder_defs.svh"

interface tone_if;
	logic [`TONE_N-1:0] clean;

	modport src (output clean);
	modport dst (input clean);
endinterface : tone_if

/* src/tick_divider.sv */
// Purpose: One-cycle enable pulse every millisecond.
// Assumes: TICK_CYCLES of at least 2.
// Notes:   Shorten TICK_CYCLES in simulation.
`timescale 1ns/1ps

module tick_divider #(
	parameter int unsigned TICK_CYCLES = 250000
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// Tick
	output logic      tick
);
	localparam int CNT_W = $clog2(TICK_CYCLES);

	logic [CNT_W-1:0] cnt;

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else if (cnt == CNT_W'(TICK_CYCLES - 1)) begin
			cnt  <= '0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule : tick_divider

/* src/tone_debounce.sv */
// Purpose: Synchronise and debounce the four reed detector inputs.
// Assumes: Tick is a 1 ms enable on the same clock.
// Notes:   A level must stand for the debounce time before it is passed on.
`timescale 1ns/1ps
`include "tone_decoder_defs.svh"

module tone_debounce (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                srst,
	input  wire logic                tick,
	// Raw detector pins
	input  wire logic [`TONE_N-1:0]  tone_raw,
	// Cleaned levels
	tone_if.src                      tones
);
	for (genvar i = 0; i < `TONE_N; i++) begin : g_tone
		logic            sync1;
		logic            sync2;
		logic            stable;
		logic [`DB_W-1:0] cnt;

		always_ff @(posedge clock) begin
			if (srst) begin
				sync1 <= 1'b0;
				sync2 <= 1'b0;
			end else begin
				sync1 <= tone_raw[i];
				sync2 <= sync1;
			end
		end

		always_ff @(posedge clock) begin
			if (srst) begin
				stable <= 1'b0;
				cnt    <= '0;
			end else if (sync2 == stable) begin
				cnt <= '0;
			end else if (tick) begin
				if (cnt == `DB_W'(`DEBOUNCE_MS - 1)) begin
					stable <= sync2;
					cnt    <= '0;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end

		assign tones.clean[i] = stable;
	end

endmodule : tone_debounce

/* src/sequential_tone_call_decoder.sv */
// Purpose: Sequential two-pulse and group tone call decoder with APB control.
// Assumes: One 250 MHz clock, synchronous active-high reset, panel pins asynchronous.
// Notes:   Lamp stays latched, and relays stay on while their switch is enabled, until an operator or software reset.
//
// What this block does
// - Individual call is exactly two successive pulses of two simultaneous tones.
// - Individual call only when first pair, then second pair, arrive in order.
// - First pulse from detectors 1A, 1B; second pulse from 2A, 2B.
// - Group call pair is detectors 1B and 2A.
// - Group call needs both tones unbroken for three seconds; dropout restarts.
// - Without a valid code, receiver stays muted unless mic off hook or monitor switch, and indicators stay off.
// - Valid call lights the call lamp and starts the alert tone.
// - Call lamp stays latched until operator or software reset.
// - Tone-only mode unmutes for five seconds after the alert ends.
// - Tone-and-voice mode unmutes from alert end until operator or software reset.
// - Valid call can energise the lights and horn relays.
// - Horn and lights relays each gated by their own enable switch.
// - Mic off hook or monitor switch removes all muting.
`timescale 1ns/1ps
`include "tone_decoder_defs.svh"

module sequential_tone_call_decoder
	import tone_decoder_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                srst,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [`ADDR_W-1:0]  paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic                     irq,
	// Reed detector pins
	input  wire logic [`TONE_N-1:0]  tone_raw,
	// Operator panel pins
	input  wire logic                operator_reset,
	input  wire logic                horn_enable_sw,
	input  wire logic                lights_enable_sw,
	input  wire logic                mic_off_hook,
	input  wire logic                monitor_sw,
	// Call indications
	output logic                     call_lamp,
	output logic                     alert_tone,
	output logic                     horn_relay,
	output logic                     lights_relay,
	output logic                     rx_mute
);
	localparam int MW = `MS_W;
	localparam logic [MW-1:0] FIRST_MIN  = MW'(`FIRST_NOM_MS - `FIRST_TOL_MS);
	localparam logic [MW-1:0] FIRST_MAX  = MW'(`FIRST_NOM_MS + `FIRST_TOL_MS);
	localparam logic [MW-1:0] GAP_MAX    = MW'(`GAP_MAX_MS);
	localparam logic [MW-1:0] SECOND_MIN = MW'(`SECOND_NOM_MS - `SECOND_TOL_MS);
	localparam logic [MW-1:0] SECOND_MAX = MW'(`SECOND_NOM_MS + `SECOND_TOL_MS);
	localparam logic [MW-1:0] GROUP_HOLD = MW'(`GROUP_HOLD_MS);
	localparam logic [MW-1:0] ALERT_LEN  = MW'(`ALERT_MS);
	localparam logic [MW-1:0] MONITOR_LEN = MW'(`MONITOR_MS);

	// ----------------------------------------
	// Tick and tone conditioning
	// ----------------------------------------
	logic   tick;
	tone_if tones ();

	tick_divider #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clock (clock),
		.srst  (srst),
		.tick  (tick)
	);

	tone_debounce u_debounce (
		.clock    (clock),
		.srst     (srst),
		.tick     (tick),
		.tone_raw (tone_raw),
		.tones    (tones.src)
	);

	// ----------------------------------------
	// Panel synchronisers
	// ----------------------------------------
	logic [4:0] panel_s1;
	logic [4:0] panel_s2;
	logic       op_reset;
	logic       horn_en;
	logic       lights_en;
	logic       off_hook;
	logic       monitor_on;

	always_ff @(posedge clock) begin
		if (srst) begin
			panel_s1 <= '0;
			panel_s2 <= '0;
		end else begin
			panel_s1 <= {operator_reset, horn_enable_sw, lights_enable_sw, mic_off_hook, monitor_sw};
			panel_s2 <= panel_s1;
		end
	end

	assign {op_reset, horn_en, lights_en, off_hook, monitor_on} = panel_s2;

	// ----------------------------------------
	// Tone pairs
	// ----------------------------------------
	logic pair1;
	logic pair2;
	logic any1;
	logic any2;
	logic group_pair;

	assign pair1      = tones.clean[`TONE_1A] & tones.clean[`TONE_1B];
	assign pair2      = tones.clean[`TONE_2A] & tones.clean[`TONE_2B];
	assign any1       = tones.clean[`TONE_1A] | tones.clean[`TONE_1B];
	assign any2       = tones.clean[`TONE_2A] | tones.clean[`TONE_2B];
	assign group_pair = tones.clean[`TONE_1B] & tones.clean[`TONE_2A];

	// ----------------------------------------
	// Individual call sequence
	// ----------------------------------------
	seq_state_t     seq_state;
	logic [MW-1:0]  seq_cnt;
	logic           indiv_hit;
	logic           seq_abort;

	always_ff @(posedge clock) begin
		if (srst) begin
			seq_state <= SEQ_IDLE;
			seq_cnt   <= '0;
			indiv_hit <= 1'b0;
			seq_abort <= 1'b0;
		end else begin
			indiv_hit <= 1'b0;
			seq_abort <= 1'b0;
			if (tick && seq_cnt != '1) begin
				seq_cnt <= seq_cnt + 1'b1;
			end
			unique case (seq_state)
				SEQ_IDLE: begin
					if (pair1 && !any2) begin
						seq_state <= SEQ_FIRST;
						seq_cnt   <= '0;
					end
				end
				SEQ_FIRST: begin
					if (any2) begin
						seq_state <= SEQ_IDLE;
						seq_abort <= 1'b1;
					end else if (!pair1) begin
						if (seq_cnt >= FIRST_MIN && seq_cnt <= FIRST_MAX) begin
							seq_state <= SEQ_GAP;
						end else begin
							seq_state <= SEQ_IDLE;
							seq_abort <= 1'b1;
						end
						seq_cnt <= '0;
					end
				end
				SEQ_GAP: begin
					if (pair2 && !any1) begin
						seq_state <= SEQ_SECOND;
						seq_cnt   <= '0;
					end else if (seq_cnt > GAP_MAX || pair1) begin
						seq_state <= SEQ_IDLE;
						seq_abort <= 1'b1;
					end
				end
				SEQ_SECOND: begin
					if (any1 || seq_cnt > SECOND_MAX) begin
						seq_state <= SEQ_IDLE;
						seq_abort <= 1'b1;
					end else if (!pair2) begin
						seq_state <= SEQ_IDLE;
						if (seq_cnt >= SECOND_MIN) begin
							indiv_hit <= 1'b1;
						end else begin
							seq_abort <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Group call hold timer
	// ----------------------------------------
	logic [MW-1:0] grp_cnt;
	logic          grp_fired;
	logic          group_hit;

	always_ff @(posedge clock) begin
		if (srst) begin
			grp_cnt   <= '0;
			grp_fired <= 1'b0;
			group_hit <= 1'b0;
		end else begin
			group_hit <= 1'b0;
			if (!group_pair) begin
				grp_cnt   <= '0;
				grp_fired <= 1'b0;
			end else if (!grp_fired) begin
				if (grp_cnt >= GROUP_HOLD) begin
					group_hit <= 1'b1;
					grp_fired <= 1'b1;
				end else if (tick) begin
					grp_cnt <= grp_cnt + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Call handling
	// ----------------------------------------
	call_state_t   call_state;
	logic [MW-1:0] call_cnt;
	logic          tone_only;
	logic          soft_reset;
	logic          clear_call;

	assign clear_call = op_reset | soft_reset;

	always_ff @(posedge clock) begin
		if (srst) begin
			call_state <= CALL_IDLE;
			call_cnt   <= '0;
		end else if (clear_call) begin
			call_state <= CALL_IDLE;
			call_cnt   <= '0;
		end else begin
			if (tick && call_cnt != '1) begin
				call_cnt <= call_cnt + 1'b1;
			end
			unique case (call_state)
				CALL_IDLE: begin
					if (indiv_hit || group_hit) begin
						call_state <= CALL_ALERT;
						call_cnt   <= '0;
					end
				end
				CALL_ALERT: begin
					if (call_cnt >= ALERT_LEN) begin
						call_state <= tone_only ? CALL_MONITOR : CALL_HELD;
						call_cnt   <= '0;
					end
				end
				CALL_MONITOR: begin
					if (call_cnt >= MONITOR_LEN) begin
						call_state <= CALL_DONE;
					end
				end
				CALL_HELD: ;
				CALL_DONE: ;
			endcase
		end
	end

	// ----------------------------------------
	// Output drivers
	// ----------------------------------------
	logic called;
	logic unmute_call;

	assign called      = call_state != CALL_IDLE;
	assign unmute_call = call_state == CALL_MONITOR || call_state == CALL_HELD;

	always_ff @(posedge clock) begin
		if (srst) begin
			call_lamp    <= 1'b0;
			alert_tone   <= 1'b0;
			horn_relay   <= 1'b0;
			lights_relay <= 1'b0;
			rx_mute      <= 1'b1;
		end else begin
			call_lamp    <= called;
			alert_tone   <= call_state == CALL_ALERT;
			horn_relay   <= called & horn_en;
			lights_relay <= called & lights_en;
			rx_mute      <= ~(unmute_call | off_hook | monitor_on);
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic                 setup;
	logic                 access;
	logic                 addr_ok;
	logic [`EVT_N-1:0]    status;
	logic [`EVT_N-1:0]    mask;
	logic [`EVT_N-1:0]    events;
	logic [31:0]          state_word;
	logic [31:0]          rd_mux;

	assign setup   = psel & ~penable;
	assign access  = psel & penable & pready;
	assign addr_ok = paddr == `REG_CTRL || paddr == `REG_STATUS || paddr == `REG_MASK || paddr == `REG_STATE;

	always_comb begin
		state_word                                 = '0;
		state_word[`ST_LAMP]                       = call_lamp;
		state_word[`ST_ALERT]                      = alert_tone;
		state_word[`ST_UNMUTE]                     = unmute_call;
		state_word[`ST_HORN]                       = horn_relay;
		state_word[`ST_LIGHTS]                     = lights_relay;
		state_word[`ST_MUTE]                       = rx_mute;
		state_word[`ST_TONES_LSB +: `TONE_N]       = tones.clean;
	end

	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			`REG_CTRL:   rd_mux[`CTRL_TONE_ONLY] = tone_only;
			`REG_STATUS: rd_mux[`EVT_N-1:0]      = status;
			`REG_MASK:   rd_mux[`EVT_N-1:0]      = mask;
			`REG_STATE:  rd_mux                  = state_word;
			default:     rd_mux                  = '0;
		endcase
	end

	// Zero wait states: answer is prepared in the setup cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~addr_ok;
			if (setup) begin
				prdata <= pwrite ? '0 : rd_mux;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			tone_only  <= 1'b0;
			mask       <= '0;
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= access & pwrite & paddr == `REG_CTRL & pwdata[`CTRL_SOFT_RESET];
			if (access && pwrite && paddr == `REG_CTRL) begin
				tone_only <= pwdata[`CTRL_TONE_ONLY];
			end
			if (access && pwrite && paddr == `REG_MASK) begin
				mask <= pwdata[`EVT_N-1:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	always_comb begin
		events             = '0;
		events[`EVT_INDIV] = indiv_hit;
		events[`EVT_GROUP] = group_hit;
		events[`EVT_ABORT] = seq_abort;
	end

	// Only bits handed out in prdata are cleared, so an event caught at the setup edge is not lost
	always_ff @(posedge clock) begin
		if (srst) begin
			status <= '0;
			irq    <= 1'b0;
		end else begin
			if (access && !pwrite && paddr == `REG_STATUS) begin
				status <= (status & ~prdata[`EVT_N-1:0]) | events;
			end else begin
				status <= status | events;
			end
			irq <= |(status & mask);
		end
	end

endmodule : sequential_tone_call_decoder

/* tb/tone_call_properties.sv */
// Purpose: Port-level properties of the tone call decoder.
// Assumes: One clock, srst synchronous and active high.
// Notes:   Panel pins pass two sync flops, so windows allow four cycles.
`timescale 1ns/1ps
`include "tone_decoder_defs.svh"

module tone_call_properties (
	// Clock and reset
	input wire logic	clock,
	input wire logic	srst,
	// Bus
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [`ADDR_W-1:0]	paddr,
	input wire logic	pready,
	input wire logic	irq,
	// Panel and indications
	input wire logic	operator_reset,
	input wire logic	horn_enable_sw,
	input wire logic	lights_enable_sw,
	input wire logic	mic_off_hook,
	input wire logic	monitor_sw,
	input wire logic	call_lamp,
	input wire logic	alert_tone,
	input wire logic	horn_relay,
	input wire logic	lights_relay,
	input wire logic	rx_mute
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	reset_clears_a:
	assert property (disable iff (1'b0) srst |=> !call_lamp && !alert_tone && !horn_relay && !lights_relay
		&& rx_mute && !irq) else $error("outputs not cleared by reset");
	alert_with_lamp_a:
	assert property (alert_tone |-> call_lamp) else $error("alert without lamp");
	horn_gate_a:
	assert property (!horn_enable_sw [*4] |-> !horn_relay) else $error("horn relay while disabled");
	lights_gate_a:
	assert property (!lights_enable_sw [*4] |-> !lights_relay) else $error("lights relay while disabled");
	relay_needs_call_a:
	assert property (horn_relay || lights_relay |-> call_lamp || $past(call_lamp))
		else $error("relay without call");
	panel_unmute_a:
	assert property ((mic_off_hook || monitor_sw) [*4] |-> !rx_mute) else $error("muted while off hook");
	idle_muted_a:
	assert property ((!call_lamp && !mic_off_hook && !monitor_sw) [*4] |-> rx_mute)
		else $error("unmuted without call");
	lamp_latched_a:
	assert property ((call_lamp && !operator_reset && !(psel && pwrite)) [*5] |=> call_lamp)
		else $error("lamp dropped without reset");
	bus_answer_a:
	assert property (psel && !penable |=> pready) else $error("no ready after setup");
	irq_read_clear_a:
	assert property (psel && penable && pready && !pwrite && paddr == `REG_STATUS |-> ##2 !irq)
		else $error("irq stays after status read");

	cover property ($rose(call_lamp));
	cover property (horn_relay);
	cover property (call_lamp && !alert_tone && !rx_mute);
endmodule : tone_call_properties

/* tb/tone_source.sv */
// Purpose: Reed detector model, holding tone patterns for set times.
// Assumes: Times are counted in 1 ms ticks of TICK_CYCLES clocks.
// Notes:   Levels are low whenever no reed vibrates.
`timescale 1ns/1ps
`include "tone_decoder_defs.svh"

module tone_source #(
	parameter int unsigned TICK_CYCLES = 3
) (
	// Clock
	input wire logic	clock,
	// Reed levels
	output logic [`TONE_N-1:0]	tone_raw
);
	initial tone_raw = 4'h0;

	task automatic play(input logic [`TONE_N-1:0] pattern, input int ms);
		@(posedge clock);
		tone_raw <= pattern;
		repeat (ms * TICK_CYCLES - 1) @(posedge clock);
	endtask : play
endmodule : tone_source

/* tb/sequential_tone_call_decoder_bench.sv */
// Purpose: Self-checking bench of the tone call decoder.
// Assumes: Tick shortened to 3 clocks so whole calls fit the run.
// Notes:   Tone timing is kept by the reed model's play calls.
`timescale 1ns/1ps
`include "tone_decoder_defs.svh"

`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module sequential_tone_call_decoder_bench;
	localparam int unsigned TC = 3;
	logic clock, srst, psel, penable, pwrite, pready, pslverr, irq, err;
	logic operator_reset, horn_enable_sw, lights_enable_sw, mic_off_hook, monitor_sw;
	logic call_lamp, alert_tone, horn_relay, lights_relay, rx_mute;
	logic [`ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [`TONE_N-1:0] tone_raw;
	int n_errors, total_checks;

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	tone_source #(.TICK_CYCLES(TC)) u_src (.clock, .tone_raw);
	sequential_tone_call_decoder #(.TICK_CYCLES(TC)) u_dut (.clock, .srst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .tone_raw, .operator_reset, .horn_enable_sw,
		.lights_enable_sw, .mic_off_hook, .monitor_sw, .call_lamp, .alert_tone, .horn_relay,
		.lights_relay, .rx_mute);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] wd);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic ticks(input int n);
		repeat (n * TC) @(posedge clock);
	endtask : ticks

	// Alert length is a design choice, so its end is waited for
	task automatic wait_alert;
		int i;
		i = 0;
		while (alert_tone !== 1'b0 && i < 2100 * TC) begin
			@(posedge clock);
			i++;
		end
		if (i >= 2100 * TC) begin
			n_errors++;
			give_verdict();
		end
		repeat (3) @(posedge clock);
	endtask : wait_alert

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{operator_reset, lights_enable_sw, mic_off_hook, monitor_sw} = 4'h0;
		horn_enable_sw = 1'b1;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		apb(1'b0, `REG_STATE, 32'h0);
		`CHECK(rd[5:0], 6'h20)
		apb(1'b0, 12'h010, 32'h0);
		`CHECK({err, rd}, {1'b1, 32'h0})
		mic_off_hook <= 1'b1;
		repeat (6) @(posedge clock);
		`CHECK(rx_mute, 1'b0)
		mic_off_hook <= 1'b0;
		monitor_sw <= 1'b1;
		repeat (6) @(posedge clock);
		`CHECK(rx_mute, 1'b0)
		monitor_sw <= 1'b0;
		$display("test idle done");

		apb(1'b1, `REG_MASK, 32'h7);
		apb(1'b1, `REG_CTRL, 32'h1);
		u_src.play(4'h3, 1250);
		u_src.play(4'h0, 200);
		u_src.play(4'hC, 1000);
		u_src.play(4'h0, 50);
		`CHECK({call_lamp, alert_tone, horn_relay, lights_relay, irq, rx_mute}, 6'b111011)
		apb(1'b0, `REG_STATUS, 32'h0);
		`CHECK(rd[2:0], 3'h1)
		wait_alert();
		`CHECK(rx_mute, 1'b0)
		ticks(4980);
		`CHECK({rx_mute, call_lamp}, 2'b01)
		ticks(40);
		`CHECK({rx_mute, call_lamp}, 2'b11)
		operator_reset <= 1'b1;
		ticks(1);
		operator_reset <= 1'b0;
		ticks(1);
		`CHECK({call_lamp, horn_relay}, 2'b00)
		$display("test individual call done");

		u_src.play(4'h3, 900);
		u_src.play(4'h0, 200);
		u_src.play(4'hC, 1000);
		u_src.play(4'h0, 50);
		apb(1'b0, `REG_STATUS, 32'h0);
		`CHECK({call_lamp, rd[2:0]}, 4'b0100)
		u_src.play(4'hC, 1000);
		u_src.play(4'h0, 200);
		u_src.play(4'h3, 1250);
		u_src.play(4'h0, 500);
		`CHECK(irq, 1'b1)
		apb(1'b1, `REG_MASK, 32'h3);
		ticks(1);
		`CHECK(irq, 1'b0)
		apb(1'b0, `REG_STATUS, 32'h0);
		`CHECK({call_lamp, rd[2:0]}, 4'b0100)
		$display("test refused sequences done");

		apb(1'b1, `REG_CTRL, 32'h0);
		horn_enable_sw <= 1'b0;
		lights_enable_sw <= 1'b1;
		u_src.play(4'h6, 1700);
		u_src.play(4'h0, 30);
		u_src.play(4'h6, 1700);
		u_src.play(4'h0, 50);
		`CHECK(call_lamp, 1'b0)
		u_src.play(4'h6, 3050);
		u_src.play(4'h0, 50);
		`CHECK({call_lamp, horn_relay, lights_relay}, 3'b101)
		wait_alert();
		ticks(200);
		`CHECK({rx_mute, call_lamp}, 2'b01)
		apb(1'b0, `REG_STATUS, 32'h0);
		`CHECK(rd[1:0], 2'b10)
		apb(1'b1, `REG_CTRL, 32'h2);
		ticks(1);
		`CHECK({call_lamp, lights_relay, rx_mute}, 3'b001)
		$display("test group call done");
		give_verdict();
	end
endmodule : sequential_tone_call_decoder_bench

bind sequential_tone_call_decoder tone_call_properties u_props (.clock, .srst, .psel, .penable, .pwrite,
	.paddr, .pready, .irq, .operator_reset, .horn_enable_sw, .lights_enable_sw, .mic_off_hook,
	.monitor_sw, .call_lamp, .alert_tone, .horn_relay, .lights_relay, .rx_mute);
